// ==== ldp_pkg.sv ====
package ldp_pkg;

	// ==================================================
	// clock and timing
	localparam int CLK_MHZ        = 200;
	localparam int STARTUP_US     = 500;
	localparam int STARTUP_CYC    = STARTUP_US * CLK_MHZ;
	localparam int IDLE_MS        = 50;
	localparam int IDLE_CYC       = IDLE_MS * 1000 * CLK_MHZ;
	localparam int LOOKAHEAD_MS   = 50;
	localparam int FAST_WAKE_US   = 1;
	localparam int FAST_WAKE_CYC  = FAST_WAKE_US * CLK_MHZ;
	localparam int SAT_FILT_CYC   = 64;
	localparam int HYST_SHIFT     = 8;
	localparam int TEMP_REF_C     = 25;

	// ==================================================
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_CTRL   = 6'h00;
	localparam logic [5:0] IDX_CFG    = 6'h01;
	localparam logic [5:0] IDX_STAT   = 6'h02;
	localparam logic [5:0] IDX_POPT   = 6'h36;
	localparam logic [5:0] IDX_SRST   = 6'h3d;
	localparam logic [7:0] SRST_KEY   = 8'hff;

	// ==================================================
	// field positions
	localparam int POPT_GAIN_LSB  = 0;
	localparam int POPT_PWMGAP    = 2;
	localparam int POPT_AUTOSLP   = 5;
	localparam int POPT_EXTCLK    = 6;
	localparam int CFG_HYST_LSB   = 0;
	localparam int CFG_TCWAKE     = 4;
	localparam int CFG_SLOPE_LSB  = 8;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_PUMP_LSB  = 4;
	localparam int STAT_BOOST     = 6;
	localparam int STAT_THERM     = 7;

	// ==================================================
	// reset values
	localparam logic [7:0] POPT_RST   = 8'h00;
	localparam logic [3:0] HYST_RST   = 4'h4;
	localparam logic [4:0] SLOPE_RST  = 5'h00;
	localparam logic [5:0] MON_MASK   = 6'h3f;

	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;

	// ==================================================
	// types
	typedef enum logic [1:0] {GS_OFF, GS_BYPASS, GS_BOOST, GS_AUTO} ldp_gain_t;
	typedef enum logic [1:0] {PM_OFF, PM_1X, PM_1X5, PM_WEAK} ldp_pump_t;
	typedef enum logic [2:0] {ST_RESET, ST_STANDBY, ST_STARTUP, ST_NORMAL, ST_PSAVE, ST_WAKE} ldp_mode_t;
	typedef enum logic [2:0] {RS_CTRL, RS_CFG, RS_STAT, RS_POPT, RS_SRST, RS_NONE} ldp_rsel_t;

	typedef struct packed {
		logic      analog_en;
		logic      osc_en;
		logic      drv_en;
		logic      pump_prot_en;
		logic      pump_pulldown;
		ldp_pump_t pump;
		logic      eng_run;
	} ldp_pwr_t;

	typedef struct packed {
		logic [8:0] led_sat;
		logic       led_active;
		logic       pwm_on;
		logic       pwm_demand;
		logic [15:0] gap_ms0;
		logic [15:0] gap_ms1;
		logic [15:0] gap_ms2;
	} ldp_led_t;

endpackage

// ==== ldp_power_ctrl.sv ====
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Contract
// - soft reset key or power clear resets registers
// - power clear release moves to standby
// - device-on bit zero after power clear
// - standby when device-on or wake pin low
// - writes accepted in standby if wake high
// - device-on with wake runs 500 us startup
// - thermal cutoff holds in startup state
// - gain select zero disables pump, pulldown in normal and wake
// - bypass, forced boost and automatic gain modes
// - auto mode monitors drivers one to six
// - auto boost on saturation, 1x when enough
// - auto mode 1x after 50 ms idle
// - saturation inputs digitally filtered
// - configurable hysteresis with factory default
// - power save only when auto sleep set
// - power save blocks depend on clock source
// - power save puts pump in weak 1x
// - enter power save on look-ahead gap
// - engines keep running in power save
// - pwm demand in power save fast-wakes
// - pwm gap bit idles analog in off phase
// - pwm duty tracks temperature, 31 slopes
// - compensation continuous or after wake only
module ldp_power_ctrl #(
	parameter int STARTUP_CYCLES = ldp_pkg::STARTUP_CYC,
	parameter int IDLE_CYCLES    = ldp_pkg::IDLE_CYC,
	parameter logic [3:0] HYST_DEFAULT = ldp_pkg::HYST_RST
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              por_active,
	input  wire logic              wake_pin,
	input  wire logic              thermal_cutoff,
	input  wire logic signed [7:0] temp_c,
	input  wire ldp_pkg::ldp_led_t led_in,
	output ldp_pkg::ldp_pwr_t      pwr_ctl,
	output logic signed [15:0]     tc_adj,
	output logic                   s_axi_awready,
	input  wire logic              s_axi_awvalid,
	input  wire logic [7:0]        s_axi_awaddr,
	output logic                   s_axi_wready,
	input  wire logic              s_axi_wvalid,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_arready,
	input  wire logic              s_axi_arvalid,
	input  wire logic [7:0]        s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp
);

	// ==================================================
	// state
	typedef struct packed {
		ldp_pkg::ldp_mode_t st;
		logic [23:0]        tmr;
		logic [23:0]        idle;
		logic [7:0]         sat_cnt;
		logic [15:0]        clr_cnt;
		logic               boost;
		logic               dev_on;
		logic [7:0]         popt;
		logic [3:0]         hyst;
		logic               tc_wake;
		logic [4:0]         slope;
		logic signed [7:0]  temp_hold;
		logic signed [15:0] tc_adj;
		ldp_pkg::ldp_pwr_t  pwr;
		logic               aw_got;
		logic               w_got;
		logic [7:0]         awaddr;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic               awready;
		logic               wready;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               arready;
		logic               rvalid;
		logic [1:0]         rresp;
		logic [31:0]        rdata;
	} ldp_state_t;

	ldp_state_t s_q;
	ldp_state_t s_d;

	// ==================================================
	// helpers
	function automatic ldp_pkg::ldp_rsel_t rsel(input logic [7:0] a);
		logic [5:0] i;
		i = a[7:2];
		if (i == ldp_pkg::IDX_CTRL) begin
			rsel = ldp_pkg::RS_CTRL;
		end else if (i == ldp_pkg::IDX_CFG) begin
			rsel = ldp_pkg::RS_CFG;
		end else if (i == ldp_pkg::IDX_STAT) begin
			rsel = ldp_pkg::RS_STAT;
		end else if (i == ldp_pkg::IDX_POPT) begin
			rsel = ldp_pkg::RS_POPT;
		end else if (i == ldp_pkg::IDX_SRST) begin
			rsel = ldp_pkg::RS_SRST;
		end else begin
			rsel = ldp_pkg::RS_NONE;
		end
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		merge = r;
	endfunction

	function automatic ldp_state_t defaults(input logic [3:0] hdef);
		ldp_state_t r;
		r         = '0;
		r.st      = ldp_pkg::ST_RESET;
		r.popt    = ldp_pkg::POPT_RST;
		r.hyst    = hdef;
		r.slope   = ldp_pkg::SLOPE_RST;
		r.awready = 1'b1;
		r.wready  = 1'b1;
		r.arready = 1'b1;
		defaults  = r;
	endfunction

	// ==================================================
	// combinational next state
	always_comb begin
		logic              wr_now;
		logic              srst;
		logic [31:0]       m;
		logic [31:0]       rd;
		logic [5:0]        sat_mon;
		logic              sat_any;
		logic              gap_ok;
		logic              ext_clk;
		logic              run_ok;
		logic [15:0]       hyst_lim;
		logic signed [8:0] dt;
		logic [23:0]       s_lim;
		logic [23:0]       i_lim;
		ldp_pkg::ldp_gain_t gsel;
		ldp_pkg::ldp_pump_t pm;
		ldp_state_t        bus_keep;

		s_d      = s_q;
		wr_now   = 1'b0;
		srst     = 1'b0;
		m        = '0;
		rd       = '0;
		sat_mon  = '0;
		sat_any  = 1'b0;
		gap_ok   = 1'b0;
		hyst_lim = '0;
		dt       = '0;
		pm       = ldp_pkg::PM_OFF;
		bus_keep = '0;
		s_lim    = 24'(STARTUP_CYCLES - 1);
		i_lim    = 24'(IDLE_CYCLES);
		ext_clk  = s_q.popt[ldp_pkg::POPT_EXTCLK];
		gsel     = ldp_pkg::ldp_gain_t'(s_q.popt[ldp_pkg::POPT_GAIN_LSB +: 2]);
		run_ok   = s_q.dev_on && wake_pin;

		// ==================================================
		// write channel: address and data in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			wr_now     = 1'b1;
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = (rsel(s_q.awaddr) == ldp_pkg::RS_NONE) ? ldp_pkg::RESP_SLV : ldp_pkg::RESP_OKAY;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		if (wr_now) begin
			m = merge('0, s_q.wdata, s_q.wstrb);
			if (rsel(s_q.awaddr) == ldp_pkg::RS_SRST && s_q.wstrb[0] && m[7:0] == ldp_pkg::SRST_KEY) begin
				srst = 1'b1;
			end
			// writes only with wake pin high
			if (wake_pin && s_q.st != ldp_pkg::ST_RESET) begin
				if (rsel(s_q.awaddr) == ldp_pkg::RS_CTRL) begin
					m = merge({31'h0000_0000, s_q.dev_on}, s_q.wdata, s_q.wstrb);
					s_d.dev_on = m[0];
				end else if (rsel(s_q.awaddr) == ldp_pkg::RS_POPT) begin
					m = merge({24'h00_0000, s_q.popt}, s_q.wdata, s_q.wstrb);
					s_d.popt = m[7:0];
				end else if (rsel(s_q.awaddr) == ldp_pkg::RS_CFG) begin
					m = {19'h0_0000, s_q.slope, 3'h0, s_q.tc_wake, s_q.hyst};
					m = merge(m, s_q.wdata, s_q.wstrb);
					s_d.hyst    = m[ldp_pkg::CFG_HYST_LSB +: 4];
					s_d.tc_wake = m[ldp_pkg::CFG_TCWAKE];
					s_d.slope   = m[ldp_pkg::CFG_SLOPE_LSB +: 5];
				end
			end
		end

		// ==================================================
		// read channel
		if (s_axi_arvalid && s_q.arready) begin
			s_d.rresp = ldp_pkg::RESP_OKAY;
			if (rsel(s_axi_araddr) == ldp_pkg::RS_CTRL) begin
				rd[0] = s_q.dev_on;
			end else if (rsel(s_axi_araddr) == ldp_pkg::RS_POPT) begin
				rd[7:0] = s_q.popt;
			end else if (rsel(s_axi_araddr) == ldp_pkg::RS_CFG) begin
				rd[ldp_pkg::CFG_HYST_LSB +: 4]  = s_q.hyst;
				rd[ldp_pkg::CFG_TCWAKE]         = s_q.tc_wake;
				rd[ldp_pkg::CFG_SLOPE_LSB +: 5] = s_q.slope;
			end else if (rsel(s_axi_araddr) == ldp_pkg::RS_STAT) begin
				rd[ldp_pkg::STAT_STATE_LSB +: 3] = s_q.st;
				rd[ldp_pkg::STAT_PUMP_LSB +: 2]  = s_q.pwr.pump;
				rd[ldp_pkg::STAT_BOOST]          = s_q.boost;
				rd[ldp_pkg::STAT_THERM]          = thermal_cutoff;
			end else if (rsel(s_axi_araddr) == ldp_pkg::RS_NONE) begin
				s_d.rresp = ldp_pkg::RESP_SLV;
			end
			s_d.rdata  = rd;
			s_d.rvalid = 1'b1;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// ==================================================
		// automatic gain: filtered saturation with hysteresis
		// drivers seven to nine ignored
		sat_mon  = led_in.led_sat[5:0] & ldp_pkg::MON_MASK;
		sat_any  = |sat_mon;
		hyst_lim = 16'({s_q.hyst, 8'h00} >> (8 - ldp_pkg::HYST_SHIFT));
		// boost needs a steady run of saturation
		if (sat_any) begin
			s_d.clr_cnt = '0;
			if (s_q.sat_cnt < 8'(ldp_pkg::SAT_FILT_CYC - 1)) begin
				s_d.sat_cnt = s_q.sat_cnt + 8'h01;
			end else begin
				s_d.boost = 1'b1;
			end
		end else begin
			s_d.sat_cnt = '0;
			if (s_q.boost && s_q.clr_cnt < hyst_lim) begin
				s_d.clr_cnt = s_q.clr_cnt + 16'h0001;
			end else if (s_q.boost) begin
				s_d.boost   = 1'b0;
				s_d.clr_cnt = '0;
			end
		end
		// idle leds return pump to 1x
		if (led_in.led_active) begin
			s_d.idle = '0;
		end else if (s_q.idle < i_lim) begin
			s_d.idle = s_q.idle + 24'h00_0001;
		end else begin
			s_d.boost = 1'b0;
		end

		// ==================================================
		// look-ahead: every engine must report a long pwm-free gap
		// gap must exceed the limit
		gap_ok = led_in.gap_ms0 > 16'(ldp_pkg::LOOKAHEAD_MS) &&
		         led_in.gap_ms1 > 16'(ldp_pkg::LOOKAHEAD_MS) &&
		         led_in.gap_ms2 > 16'(ldp_pkg::LOOKAHEAD_MS);

		// ==================================================
		// mode sequencer
		case (s_q.st)
			ldp_pkg::ST_RESET: begin
				// leave reset once power clear drops
				s_d.st = ldp_pkg::ST_STANDBY;
			end
			ldp_pkg::ST_STANDBY: begin
				if (run_ok) begin
					s_d.st  = ldp_pkg::ST_STARTUP;
					s_d.tmr = '0;
				end
			end
			ldp_pkg::ST_STARTUP: begin
				if (s_q.tmr < s_lim) begin
					s_d.tmr = s_q.tmr + 24'h00_0001;
				end else if (!thermal_cutoff) begin
					s_d.st        = ldp_pkg::ST_NORMAL;
					s_d.temp_hold = temp_c;
				end
			end
			ldp_pkg::ST_NORMAL: begin
				if (s_q.popt[ldp_pkg::POPT_AUTOSLP] && !led_in.led_active && gap_ok) begin
					s_d.st = ldp_pkg::ST_PSAVE;
				end
			end
			ldp_pkg::ST_PSAVE: begin
				if (led_in.pwm_demand || !s_q.popt[ldp_pkg::POPT_AUTOSLP]) begin
					s_d.st  = ldp_pkg::ST_WAKE;
					s_d.tmr = '0;
				end
			end
			ldp_pkg::ST_WAKE: begin
				if (s_q.tmr < 24'(ldp_pkg::FAST_WAKE_CYC - 1)) begin
					s_d.tmr = s_q.tmr + 24'h00_0001;
				end else begin
					s_d.st        = ldp_pkg::ST_NORMAL;
					s_d.temp_hold = temp_c;
				end
			end
			default: begin
				s_d.st = ldp_pkg::ST_RESET;
			end
		endcase
		if (thermal_cutoff && s_q.st inside {ldp_pkg::ST_NORMAL, ldp_pkg::ST_PSAVE, ldp_pkg::ST_WAKE}) begin
			s_d.st  = ldp_pkg::ST_STARTUP;
			s_d.tmr = s_lim;
		end
		if (s_q.st != ldp_pkg::ST_RESET && !run_ok) begin
			s_d.st = ldp_pkg::ST_STANDBY;
		end

		// ==================================================
		// temperature compensation
		// continuous tracking unless wake-only chosen
		if (!s_q.tc_wake) begin
			s_d.temp_hold = temp_c;
		end
		// linear in temperature, slope zero disables
		dt         = 9'(s_q.temp_hold) - 9'(ldp_pkg::TEMP_REF_C);
		s_d.tc_adj = 16'($signed({1'b0, s_q.slope})) * 16'(dt);

		// ==================================================
		// power outputs
		// gain field decode
		case (gsel)
			// pump off with output pulled down
			ldp_pkg::GS_OFF:    pm = ldp_pkg::PM_OFF;
			ldp_pkg::GS_BYPASS: pm = ldp_pkg::PM_1X;
			ldp_pkg::GS_BOOST:  pm = ldp_pkg::PM_1X5;
			default:            pm = s_q.boost ? ldp_pkg::PM_1X5 : ldp_pkg::PM_1X;
		endcase
		s_d.pwr = '0;
		case (s_q.st)
			ldp_pkg::ST_STARTUP: begin
				s_d.pwr.analog_en    = !thermal_cutoff;
				s_d.pwr.osc_en       = !thermal_cutoff && !ext_clk;
				s_d.pwr.pump_prot_en = 1'b1;
			end
			ldp_pkg::ST_NORMAL, ldp_pkg::ST_WAKE: begin
				s_d.pwr.analog_en     = 1'b1;
				s_d.pwr.osc_en        = !ext_clk;
				s_d.pwr.drv_en        = s_q.st == ldp_pkg::ST_NORMAL;
				s_d.pwr.pump_prot_en  = 1'b1;
				s_d.pwr.pump          = pm;
				s_d.pwr.pump_pulldown = gsel == ldp_pkg::GS_OFF;
				s_d.pwr.eng_run       = 1'b1;
				// analog idles in the pwm off phase
				if (s_q.popt[ldp_pkg::POPT_PWMGAP] && !led_in.pwm_on) begin
					s_d.pwr.analog_en = 1'b0;
				end
			end
			ldp_pkg::ST_PSAVE: begin
				s_d.pwr.analog_en    = 1'b0;
				s_d.pwr.osc_en       = !ext_clk;
				s_d.pwr.pump_prot_en = 1'b1;
				s_d.pwr.pump         = ldp_pkg::PM_WEAK;
				s_d.pwr.eng_run      = 1'b1;
			end
			default: begin
				s_d.pwr.pump_pulldown = 1'b1;
			end
		endcase

		// ready flags are registered so the ports come from flops
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready  = !s_d.w_got && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;

		// soft reset restores defaults, bus answer kept
		if (srst) begin
			bus_keep    = s_d;
			s_d         = defaults(HYST_DEFAULT);
			s_d.bvalid  = 1'b1;
			s_d.bresp   = ldp_pkg::RESP_OKAY;
			s_d.awready = 1'b0;
			s_d.wready  = 1'b0;
			// a read taken in this same cycle still gets its answer
			s_d.rvalid  = bus_keep.rvalid;
			s_d.rdata   = bus_keep.rdata;
			s_d.rresp   = bus_keep.rresp;
			s_d.arready = bus_keep.arready;
		end
	end

	// ==================================================
	// registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n || por_active) begin
			s_q <= defaults(HYST_DEFAULT);
		end else begin
			s_q <= s_d;
		end
	end

	assign pwr_ctl       = s_q.pwr;
	assign tc_adj        = s_q.tc_adj;
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready  = s_q.wready;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

endmodule

// ==== ldp_led_model.sv ====
`timescale 1ns/1ps

// ==================================================
// engine and driver side seen by the sequencer
module ldp_led_model (
	input  wire logic        ref_clk,
	input  wire logic [8:0]  sat_req,
	input  wire logic        act,
	input  wire logic        demand,
	input  wire logic [15:0] gap,
	output ldp_pkg::ldp_led_t led
);
	logic [3:0] pwm_cnt_q = 4'h0;

	always_ff @(posedge ref_clk) begin
		pwm_cnt_q <= act ? pwm_cnt_q + 4'h1 : 4'h0;
	end

	always_comb begin
		led.led_sat    = sat_req;
		led.led_active = act;
		led.pwm_on     = act && !pwm_cnt_q[3];
		led.pwm_demand = demand;
		led.gap_ms0    = gap;
		led.gap_ms1    = gap;
		led.gap_ms2    = gap;
	end
endmodule

// ==== ldp_power_ctrl_assertions.sv ====
`timescale 1ns/1ps

// ==================================================
// port checker
module ldp_power_ctrl_chk (
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic              por_active,
	input wire logic              wake_pin,
	input wire logic              thermal_cutoff,
	input wire ldp_pkg::ldp_pwr_t pwr_ctl,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_arvalid,
	input wire logic [7:0]        s_axi_araddr,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_por_clear;
		por_active |=> pwr_ctl == '0;
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("outputs on after power clear");

	property p_wake_low;
		(!wake_pin) [*3] |-> !pwr_ctl.drv_en && !pwr_ctl.analog_en;
	endproperty
	a_wake_low: assert property (p_wake_low) else $error("active while wake pin low");

	property p_thermal;
		thermal_cutoff [*3] |-> !pwr_ctl.drv_en;
	endproperty
	a_thermal: assert property (p_thermal) else $error("drivers on during thermal event");

	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write response missing");

	property p_b_stands;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_stands: assert property (p_b_stands) else $error("write response dropped");

	property p_r_stands;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stands: assert property (p_r_stands) else $error("read data dropped");

	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while data pending");

	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c |-> ##[1:2] s_axi_rvalid && s_axi_rresp == 2'h2;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_boost: cover property (pwr_ctl.pump == ldp_pkg::PM_1X5);
	c_weak: cover property (pwr_ctl.pump == ldp_pkg::PM_WEAK);
endmodule

bind ldp_power_ctrl ldp_power_ctrl_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .por_active(por_active),
	.wake_pin(wake_pin), .thermal_cutoff(thermal_cutoff), .pwr_ctl(pwr_ctl), .s_axi_awready(s_axi_awready),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_wready(s_axi_wready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arready(s_axi_arready), .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// ==== led_driver_power_mode_control_test.sv ====
`timescale 1ns/1ps

module led_driver_power_mode_control_test;
	localparam logic [7:0] A_CTRL = {ldp_pkg::IDX_CTRL, 2'b00};
	localparam logic [7:0] A_CFG  = {ldp_pkg::IDX_CFG, 2'b00};
	localparam logic [7:0] A_STAT = {ldp_pkg::IDX_STAT, 2'b00};
	localparam logic [7:0] A_POPT = {ldp_pkg::IDX_POPT, 2'b00};
	localparam logic [7:0] A_SRST = {ldp_pkg::IDX_SRST, 2'b00};
	localparam logic [31:0] M_ST  = 32'h0000_0007;
	localparam logic [31:0] M_B   = 32'h0000_0040;
	logic ref_clk, rst_n, por_active, wake_pin, thermal_cutoff, act, demand;
	logic signed [7:0]  temp_c;
	logic [8:0]         sat_req;
	logic [15:0]        gap;
	ldp_pkg::ldp_led_t  led_in;
	ldp_pkg::ldp_pwr_t  pwr_ctl;
	logic signed [15:0] tc_adj;
	logic s_axi_awready, s_axi_awvalid, s_axi_wready, s_axi_wvalid, s_axi_bvalid, s_axi_bready;
	logic s_axi_arready, s_axi_arvalid, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, got_data;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, got_resp;
	int          error_cnt, n_tests, g;

	ldp_power_ctrl #(.STARTUP_CYCLES(20), .IDLE_CYCLES(50)) dut_u (.*);
	ldp_led_model model_u (.ref_clk(ref_clk), .sat_req(sat_req), .act(act), .demand(demand), .gap(gap), .led(led_in));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop();
		$display("compares %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic fail(input string m);
		error_cnt++;
		$display("unexpected at %0t: %s", $time, m);
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) fail(m);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		got_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) begin
			fail("write hang");
			report_and_stop();
		end
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		got_data = s_axi_rdata;
		got_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) begin
			fail("read hang");
			report_and_stop();
		end
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		cmp(got_data & m, e, "register value");
	endtask

	initial begin
		{rst_n, por_active, wake_pin, thermal_cutoff, act, demand, sat_req, gap} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		temp_c = 8'sh28;
		cyc(12);
		rst_n <= 1'b1;
		cyc(2);
		chk(A_STAT, M_ST, 32'h0000_0001);
		chk(A_CTRL, 32'h0000_0001, 32'h0000_0000);
		wr(A_POPT, 32'h0000_0003);
		chk(A_POPT, 32'h0000_00ff, 32'h0000_0000);
		wake_pin <= 1'b1;
		cyc(20);
		wr(A_POPT, 32'h0000_0001);
		chk(A_POPT, 32'h0000_00ff, 32'h0000_0001);
		chk(A_STAT, M_ST, 32'h0000_0001);
		$display("reset and standby done");
		wr(A_CTRL, 32'h0000_0001);
		chk(A_STAT, M_ST, 32'h0000_0002);
		cyc(25);
		chk(A_STAT, M_ST, 32'h0000_0003);
		for (g = 0; g < 3; g++) begin
			wr(A_POPT, 32'(g));
			cyc(3);
			cmp(32'(pwr_ctl.pump), g == 0 ? 32'(ldp_pkg::PM_OFF) : 32'(g), "pump mode");
			cmp(32'(pwr_ctl.pump_pulldown), 32'(g == 0), "pump pulldown");
		end
		$display("startup and gain modes done");
		thermal_cutoff <= 1'b1;
		cyc(30);
		chk(A_STAT, M_ST, 32'h0000_0002);
		thermal_cutoff <= 1'b0;
		cyc(30);
		chk(A_STAT, M_ST, 32'h0000_0003);
		$display("thermal done");
		wr(A_POPT, 32'h0000_0003);
		act <= 1'b1;
		sat_req <= 9'h1c0;
		cyc(100);
		chk(A_STAT, M_B, 32'h0000_0000);
		sat_req <= 9'h001;
		cyc(10);
		sat_req <= 9'h000;
		cyc(80);
		chk(A_STAT, M_B, 32'h0000_0000);
		sat_req <= 9'h020;
		cyc(100);
		chk(A_STAT, M_B, 32'h0000_0040);
		cmp(32'(pwr_ctl.pump), 32'(ldp_pkg::PM_1X5), "auto boost pump");
		sat_req <= 9'h000;
		cyc(300);
		chk(A_STAT, M_B, 32'h0000_0040);
		wr(A_POPT, 32'h0000_0007);
		cyc(3);
		g = 0;
		repeat (32) begin
			@(posedge ref_clk);
			if (!pwr_ctl.analog_en) g++;
		end
		cmp(32'(g), 32'h0000_0010, "analog off in pwm low phase");
		act <= 1'b0;
		cyc(70);
		chk(A_STAT, M_B, 32'h0000_0000);
		$display("auto gain done");
		wr(A_CFG, 32'h0000_0304);
		cyc(3);
		cmp(32'(tc_adj), 32'(3 * (40 - ldp_pkg::TEMP_REF_C)), "compensation");
		wr(A_CFG, 32'h0000_0314);
		temp_c <= 8'sh1e;
		cyc(3);
		cmp(32'(tc_adj), 32'(3 * (40 - ldp_pkg::TEMP_REF_C)), "wake-only hold");
		gap <= 16'h0064;
		cyc(5);
		chk(A_STAT, M_ST, 32'h0000_0003);
		wr(A_POPT, 32'h0000_0023);
		cyc(5);
		chk(A_STAT, M_ST, 32'h0000_0004);
		cmp(32'(pwr_ctl.pump), 32'(ldp_pkg::PM_WEAK), "weak pump");
		cmp(32'(pwr_ctl.eng_run), 32'h0000_0001, "engines run");
		cmp(32'({pwr_ctl.osc_en, pwr_ctl.drv_en, pwr_ctl.analog_en}), 32'h0000_0004, "internal clock save");
		gap <= 16'h0000;
		demand <= 1'b1;
		cyc(3);
		chk(A_STAT, M_ST, 32'h0000_0005);
		demand <= 1'b0;
		cyc(220);
		chk(A_STAT, M_ST, 32'h0000_0003);
		cmp(32'(tc_adj), 32'(3 * (30 - ldp_pkg::TEMP_REF_C)), "compensation after wake");
		$display("power save done");
		rd(8'h0c);
		cmp(32'(got_resp), 32'(ldp_pkg::RESP_SLV), "unmapped read");
		wr(8'h10, 32'h0000_0001);
		cmp(32'(got_resp), 32'(ldp_pkg::RESP_SLV), "unmapped write");
		wake_pin <= 1'b0;
		cyc(3);
		chk(A_STAT, M_ST, 32'h0000_0001);
		wake_pin <= 1'b1;
		cyc(20);
		wr(A_SRST, 32'h0000_00ff);
		cyc(2);
		chk(A_CTRL, 32'h0000_0001, 32'h0000_0000);
		chk(A_POPT, 32'h0000_00ff, 32'h0000_0000);
		wr(A_POPT, 32'h0000_0001);
		wr(A_CTRL, 32'h0000_0001);
		por_active <= 1'b1;
		cyc(2);
		por_active <= 1'b0;
		cyc(3);
		chk(A_STAT, M_ST, 32'h0000_0001);
		chk(A_POPT, 32'h0000_00ff, 32'h0000_0000);
		chk(A_CTRL, 32'h0000_0001, 32'h0000_0000);
		$display("bus and resets done");
		report_and_stop();
	end
endmodule
